// >>> verilog/aprf_pkg.sv
package aprf_pkg;

  // memory-mapped register indexes, as printed
  localparam logic [6:0] APRF_MMR_TEMP0 = 7'h20;
  localparam logic [6:0] APRF_MMR_TEMP1 = 7'h21;
  localparam logic [6:0] APRF_MMR_TEMP2 = 7'h22;
  localparam logic [6:0] APRF_MMR_TEMP3 = 7'h23;
  localparam logic [6:0] APRF_MMR_AUX0 = 7'h10;
  localparam logic [6:0] APRF_MMR_AUX4 = 7'h14;
  localparam logic [6:0] APRF_MMR_COEFF = 7'h27;
  localparam logic [6:0] APRF_MMR_CSIZE_LO = 7'h19;
  localparam logic [6:0] APRF_MMR_CSIZE_HI = 7'h30;
  localparam logic [6:0] APRF_MMR_CSIZE_CO = 7'h31;
  localparam logic [6:0] APRF_MMR_START01 = 7'h32;
  localparam logic [6:0] APRF_MMR_START_CO = 7'h36;
  localparam logic [6:0] APRF_MMR_COEFF_PAGE = 7'h4F;

  // field layout of a 23-bit address
  localparam int APRF_OFS_W = 16;
  localparam int APRF_PAGE_W = 7;
  localparam int APRF_ADDR_W = 23;
  localparam int APRF_NUM_AUX = 8;
  localparam int APRF_NUM_TEMP = 4;
  localparam int APRF_NUM_START = 5;
  localparam int APRF_NUM_SIZE = 3;
  localparam logic [1:0] APRF_SHIFT_TEMP = 2'h2;
  localparam logic [3:0] APRF_SEL_COEFF = 4'h8;
  localparam logic [2:0] APRF_START_COEFF = 3'h4;
  localparam logic [1:0] APRF_SIZE_COEFF = 2'h2;
  localparam logic [15:0] APRF_RST16 = 16'h0000;
  localparam logic [6:0] APRF_RST7 = 7'h00;

  // address-unit alu operations on pointer low halves
  typedef enum logic [2:0] {
    APRF_ALU_NONE,
    APRF_ALU_ADD,
    APRF_ALU_SUB,
    APRF_ALU_AND,
    APRF_ALU_OR,
    APRF_ALU_XOR,
    APRF_ALU_SHL,
    APRF_ALU_SHR
  } aprf_alu_op_type;

  // pointer update kinds in the address generator
  typedef enum logic [1:0] {
    APRF_MOD_NONE,
    APRF_MOD_LINEAR,
    APRF_MOD_LOCAL
  } aprf_mod_type;

  // memory-mapped access
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [15:0] wdata;
  } aprf_mmr_type;

  // dedicated full-width pointer access; index 8 is the coefficient pointer
  typedef struct packed {
    logic wr;
    logic [3:0] sel;
    logic [22:0] wdata;
  } aprf_ext_type;

  // temporary register write, swap with an aux pointer low half
  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [15:0] wdata;
    logic swap;
    logic [2:0] swap_aux;
  } aprf_temp_type;

  // address-unit alu request
  typedef struct packed {
    aprf_alu_op_type op;
    logic [2:0] dst;
    logic [15:0] operand;
  } aprf_alu_type;

  // address generation request
  typedef struct packed {
    aprf_mod_type kind;
    logic [3:0] sel;
    logic [15:0] step;
  } aprf_agen_type;

  // whole register state
  typedef struct packed {
    logic [3:0][15:0] temp;
    logic [7:0][15:0] aux_low;
    logic [7:0][6:0] aux_page;
    logic [15:0] coeff_low;
    logic [6:0] coeff_page;
    logic [4:0][15:0] start;
    logic [2:0][15:0] csize;
    logic [15:0] mmr_rdata;
    logic [22:0] addr;
    logic [22:0] coeff_addr;
    logic [22:0] ext_rdata;
  } aprf_state_type;

endpackage : aprf_pkg

// >>> verilog/aprf_regfile.sv
`timescale 1ns/1ps
// Notes on behaviour
// - four 16-bit temporary registers feed multiplies and act as scratch.
// - any temporary register may be picked as the shift count.
// - swap exchanges an aux pointer low half with a temporary register.
// - in legacy mode the multiplier and shift selects see the accumulator shift field for the third temporary register; its mapped read does not.
// - eight aux pointers, 7-bit page above 16-bit offset, 23-bit address.
// - full pointers by dedicated access only; low halves memory-mapped, pages not.
// - alu works on low halves in the same cycle as address updates.
// - address updates use 23-bit arithmetic and carry into the page.
// - stack, i/o, register-bit and direct updates stay in the low 16 bits.
// - coefficient pointer has a 7-bit page above its 16-bit low half.
// - coefficient low and page memory-mapped; extended pointer not memory-mapped.
// - coefficient pointer gives a third independent operand address.
// - five 16-bit start registers accept any value, no alignment.
// - start address added only when status two selects circular mode.
// - start registers serve pointer pairs and the coefficient pointer; page from pointer.
// - circular address is own page joined with low half plus start.
// - three size registers; legacy mode makes the first serve all aux pointers.
module aprf_regfile
  import aprf_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode and status inputs from the cpu
  input wire logic i_legacy_compat_mode,
  input wire logic [4:0] i_accum_shift_mode_field,
  input wire logic [8:0] i_status_reg_two_circ,
  // register accesses
  input wire aprf_mmr_type i_mmr,
  input wire aprf_ext_type i_ext,
  input wire aprf_temp_type i_temp,
  input wire aprf_alu_type i_alu,
  input wire aprf_agen_type i_agen,
  // operand selects
  input wire logic [1:0] i_mult_sel,
  input wire logic [1:0] i_shift_sel,
  // results
  output logic [15:0] o_mmr_rdata,
  output logic [22:0] o_ext_rdata,
  output logic [22:0] o_data_addr,
  output logic [22:0] o_coeff_addr,
  output logic [15:0] o_mult_operand,
  output logic [15:0] o_shift_count,
  output logic [2:0][15:0] o_circ_size
);

  aprf_state_type state_reg;
  aprf_state_type state_next;

  // index of the start register serving a pointer select
  function automatic logic [2:0] start_index(input logic [3:0] sel);
    if (sel == APRF_SEL_COEFF) begin
      return APRF_START_COEFF;
    end
    return sel[2:0] >> 1;
  endfunction : start_index

  // effective temporary register value, legacy mode binds the third one
  function automatic logic [15:0] temp_value(input aprf_state_type s, input logic [1:0] sel,
                                             input logic legacy, input logic [4:0] asm_f);
    if (legacy && sel == APRF_SHIFT_TEMP) begin
      return {{11{asm_f[4]}}, asm_f};
    end
    return s.temp[sel];
  endfunction : temp_value

  // circular-aware 23-bit address of a pointer
  function automatic logic [22:0] ptr_addr(input aprf_state_type s, input logic [3:0] sel,
                                           input logic [8:0] circ);
    logic [6:0] page;
    logic [15:0] low;
    logic [15:0] base;
    page = (sel == APRF_SEL_COEFF) ? s.coeff_page : s.aux_page[sel[2:0]];
    low = (sel == APRF_SEL_COEFF) ? s.coeff_low : s.aux_low[sel[2:0]];
    base = circ[sel] ? s.start[start_index(sel)] : APRF_RST16;
    return {page, 16'(low + base)};
  endfunction : ptr_addr

  // read of the mapped space
  function automatic logic [15:0] mmr_read(input aprf_state_type s, input logic [6:0] a);
    logic [15:0] d;
    d = APRF_RST16;
    case (a)
      APRF_MMR_TEMP0, APRF_MMR_TEMP1, APRF_MMR_TEMP2, APRF_MMR_TEMP3: begin
        d = s.temp[2'(a - APRF_MMR_TEMP0)];
      end
      APRF_MMR_COEFF: d = s.coeff_low;
      APRF_MMR_COEFF_PAGE: d = {9'h000, s.coeff_page};
      APRF_MMR_CSIZE_LO: d = s.csize[0];
      APRF_MMR_CSIZE_HI: d = s.csize[1];
      APRF_MMR_CSIZE_CO: d = s.csize[APRF_SIZE_COEFF];
      default: begin
        if (a >= APRF_MMR_AUX0 && a < APRF_MMR_AUX0 + 7'(APRF_NUM_AUX)) begin
          d = s.aux_low[3'(a - APRF_MMR_AUX0)];
        end else if (a >= APRF_MMR_START01 && a <= APRF_MMR_START_CO) begin
          d = s.start[3'(a - APRF_MMR_START01)];
        end
      end
    endcase
    return d;
  endfunction : mmr_read

  // next-state logic
  always_comb begin
    logic [3:0] s;
    logic [22:0] full;
    logic [15:0] t;
    logic [15:0] r;
    state_next = state_reg;
    s = i_agen.sel;
    full = {APRF_RST7, APRF_RST16};
    t = APRF_RST16;
    r = APRF_RST16;
    // mapped writes only touch the addressed half
    if (i_mmr.wr) begin
      case (i_mmr.addr)
        APRF_MMR_TEMP0, APRF_MMR_TEMP1, APRF_MMR_TEMP2, APRF_MMR_TEMP3: begin
          state_next.temp[2'(i_mmr.addr - APRF_MMR_TEMP0)] = i_mmr.wdata;
        end
        APRF_MMR_COEFF: state_next.coeff_low = i_mmr.wdata;
        APRF_MMR_COEFF_PAGE: state_next.coeff_page = i_mmr.wdata[6:0];
        APRF_MMR_CSIZE_LO: state_next.csize[0] = i_mmr.wdata;
        APRF_MMR_CSIZE_HI: state_next.csize[1] = i_mmr.wdata;
        APRF_MMR_CSIZE_CO: state_next.csize[APRF_SIZE_COEFF] = i_mmr.wdata;
        default: begin
          if (i_mmr.addr >= APRF_MMR_AUX0 && i_mmr.addr < APRF_MMR_AUX0 + 7'(APRF_NUM_AUX)) begin
            state_next.aux_low[3'(i_mmr.addr - APRF_MMR_AUX0)] = i_mmr.wdata;
          end else if (i_mmr.addr >= APRF_MMR_START01 && i_mmr.addr <= APRF_MMR_START_CO) begin
            state_next.start[3'(i_mmr.addr - APRF_MMR_START01)] = i_mmr.wdata;
          end
        end
      endcase
    end
    // dedicated full-pointer writes, the only direct write to the aux pages; linear generator updates also carry into them
    if (i_ext.wr) begin
      if (i_ext.sel == APRF_SEL_COEFF) begin
        state_next.coeff_page = i_ext.wdata[22:16];
        state_next.coeff_low = i_ext.wdata[15:0];
      end else if (!i_ext.sel[3]) begin
        state_next.aux_page[i_ext.sel[2:0]] = i_ext.wdata[22:16];
        state_next.aux_low[i_ext.sel[2:0]] = i_ext.wdata[15:0];
      end
    end
    // temporary write, then swap which sees the pre-cycle values
    if (i_temp.wr) begin
      state_next.temp[i_temp.sel] = i_temp.wdata;
    end
    if (i_temp.swap) begin
      state_next.temp[i_temp.sel] = state_reg.aux_low[i_temp.swap_aux];
      state_next.aux_low[i_temp.swap_aux] = state_reg.temp[i_temp.sel];
    end
    // address-unit alu on a low half
    t = state_reg.aux_low[i_alu.dst];
    case (i_alu.op)
      APRF_ALU_ADD: r = 16'(t + i_alu.operand);
      APRF_ALU_SUB: r = 16'(t - i_alu.operand);
      APRF_ALU_AND: r = t & i_alu.operand;
      APRF_ALU_OR: r = t | i_alu.operand;
      APRF_ALU_XOR: r = t ^ i_alu.operand;
      APRF_ALU_SHL: r = t << i_alu.operand[3:0];
      APRF_ALU_SHR: r = t >> i_alu.operand[3:0];
      default: r = t;
    endcase
    if (i_alu.op != APRF_ALU_NONE) begin
      state_next.aux_low[i_alu.dst] = r;
    end
    // generator update in the same cycle; a clash on one pointer favours the generator
    full = (s == APRF_SEL_COEFF) ? {state_reg.coeff_page, state_reg.coeff_low}
                                 : {state_reg.aux_page[s[2:0]], state_reg.aux_low[s[2:0]]};
    case (i_agen.kind)
      APRF_MOD_LINEAR: full = 23'(full + {7'h00, i_agen.step});
      APRF_MOD_LOCAL: full = {full[22:16], 16'(full[15:0] + i_agen.step)};
      default: full = full;
    endcase
    if (i_agen.kind != APRF_MOD_NONE && (s == APRF_SEL_COEFF || !s[3])) begin
      if (s == APRF_SEL_COEFF) begin
        state_next.coeff_page = full[22:16];
        state_next.coeff_low = full[15:0];
      end else begin
        state_next.aux_page[s[2:0]] = full[22:16];
        state_next.aux_low[s[2:0]] = full[15:0];
      end
    end
    // registered read data and addresses
    state_next.mmr_rdata = mmr_read(state_reg, i_mmr.addr);
    state_next.ext_rdata = (i_ext.sel == APRF_SEL_COEFF) ? {state_reg.coeff_page, state_reg.coeff_low}
                         : {state_reg.aux_page[i_ext.sel[2:0]], state_reg.aux_low[i_ext.sel[2:0]]};
    state_next.addr = ptr_addr(state_reg, (s == APRF_SEL_COEFF) ? s : {1'b0, s[2:0]},
                               i_status_reg_two_circ);
    state_next.coeff_addr = ptr_addr(state_reg, APRF_SEL_COEFF, i_status_reg_two_circ);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign o_mmr_rdata = state_reg.mmr_rdata;
  assign o_ext_rdata = state_reg.ext_rdata;
  assign o_data_addr = state_reg.addr;
  assign o_coeff_addr = state_reg.coeff_addr;
  // operand selects read live registers; the legacy binding hides the third one
  assign o_mult_operand = temp_value(state_reg, i_mult_sel, i_legacy_compat_mode,
                                     i_accum_shift_mode_field);
  assign o_shift_count = temp_value(state_reg, i_shift_sel, i_legacy_compat_mode,
                                    i_accum_shift_mode_field);
  // legacy mode: first size register serves every aux pointer
  assign o_circ_size[0] = state_reg.csize[0];
  assign o_circ_size[1] = i_legacy_compat_mode ? state_reg.csize[0] : state_reg.csize[1];
  assign o_circ_size[2] = state_reg.csize[APRF_SIZE_COEFF];

endmodule : aprf_regfile

// >>> dv/aprf_regfile_properties.sv
`timescale 1ns/1ps
module aprf_regfile_chk
  import aprf_pkg::*;
(
  // watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_legacy_compat_mode,
  input wire logic [4:0] i_accum_shift_mode_field,
  input wire aprf_mmr_type i_mmr,
  input wire aprf_ext_type i_ext,
  input wire aprf_temp_type i_temp,
  input wire aprf_alu_type i_alu,
  input wire aprf_agen_type i_agen,
  input wire logic [1:0] i_mult_sel,
  input wire logic [1:0] i_shift_sel,
  input wire logic [15:0] o_mmr_rdata,
  input wire logic [22:0] o_ext_rdata,
  input wire logic [15:0] o_mult_operand,
  input wire logic [15:0] o_shift_count,
  input wire logic [2:0][15:0] o_circ_size
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // later writers win, so read-back only holds while they idle
  wire logic late_idle = !i_temp.swap && i_alu.op == APRF_ALU_NONE && i_agen.kind == APRF_MOD_NONE;
  wire logic mapped = i_mmr.addr inside {[7'h10:7'h17], 7'h19, [7'h20:7'h23], 7'h27, [7'h30:7'h36], 7'h4F};
  wire logic lgc = i_legacy_compat_mode;
  wire logic [15:0] asm_sx = {{11{i_accum_shift_mode_field[4]}}, i_accum_shift_mode_field};
  sequence s_mmr_wr_rd;
    i_mmr.wr && mapped && i_mmr.addr != 7'h4F && !i_ext.wr && !i_temp.wr && late_idle
      ##1 !i_mmr.wr && i_mmr.addr == $past(i_mmr.addr);
  endsequence
  sequence s_ext_wr_rd;
    i_ext.wr && i_ext.sel <= 4'h8 && late_idle ##1 i_ext.sel == $past(i_ext.sel);
  endsequence
  a_mmr_read_back: assert property (s_mmr_wr_rd |=> o_mmr_rdata == $past(i_mmr.wdata, 2))
    else $error("mapped read-back mismatch");
  a_unmapped_reads_zero: assert property (!mapped |=> o_mmr_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ext_read_back: assert property (s_ext_wr_rd |=> o_ext_rdata == $past(i_ext.wdata, 2))
    else $error("full pointer read-back mismatch");
  a_mult_legacy_bind: assert property (lgc && i_mult_sel == 2'h2 |-> o_mult_operand == asm_sx)
    else $error("multiplicand ignores shift field");
  a_shift_legacy_bind: assert property (lgc && i_shift_sel == 2'h2 |-> o_shift_count == asm_sx)
    else $error("shift count ignores shift field");
  a_size_legacy_share: assert property (lgc |-> o_circ_size[1] == o_circ_size[0])
    else $error("size not shared in legacy mode");
  a_temp_mult_path: assert property (i_temp.wr && !i_temp.swap |=> i_mult_sel != $past(i_temp.sel)
    || (lgc && i_mult_sel == 2'h2) || o_mult_operand == $past(i_temp.wdata))
    else $error("multiplicand not from temp");
  a_temp_shift_path: assert property (i_temp.wr && !i_temp.swap |=> i_shift_sel != $past(i_temp.sel)
    || (lgc && i_shift_sel == 2'h2) || o_shift_count == $past(i_temp.wdata))
    else $error("shift count not from temp");
endmodule : aprf_regfile_chk

bind aprf_regfile aprf_regfile_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_legacy_compat_mode(i_legacy_compat_mode), .i_accum_shift_mode_field(i_accum_shift_mode_field),
  .i_mmr(i_mmr), .i_ext(i_ext), .i_temp(i_temp), .i_alu(i_alu), .i_agen(i_agen),
  .i_mult_sel(i_mult_sel), .i_shift_sel(i_shift_sel), .o_mmr_rdata(o_mmr_rdata),
  .o_ext_rdata(o_ext_rdata), .o_mult_operand(o_mult_operand), .o_shift_count(o_shift_count),
  .o_circ_size(o_circ_size));

// >>> dv/test_aprf_regfile.sv
`timescale 1ns/1ps
module test_aprf_regfile
  import aprf_pkg::*;
;
  logic i_clk, i_rst_n, i_legacy_compat_mode;
  logic [4:0] i_accum_shift_mode_field;
  logic [8:0] i_status_reg_two_circ;
  aprf_mmr_type i_mmr;
  aprf_ext_type i_ext;
  aprf_temp_type i_temp;
  aprf_alu_type i_alu;
  aprf_agen_type i_agen;
  logic [1:0] i_mult_sel, i_shift_sel;
  logic [15:0] o_mmr_rdata, o_mult_operand, o_shift_count;
  logic [22:0] o_ext_rdata, o_data_addr, o_coeff_addr;
  logic [2:0][15:0] o_circ_size;
  int n_errors, comparisons;
  logic [6:0] tab[21] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h19, 7'h20, 7'h21,
    7'h22, 7'h23, 7'h27, 7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36};
  logic [15:0] alu_exp[7] = '{16'h0F12, 16'h0F0C, 16'h0003, 16'h0F0F, 16'h0F0C, 16'h7878, 16'h01E1};

  aprf_regfile u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_legacy_compat_mode(i_legacy_compat_mode),
    .i_accum_shift_mode_field(i_accum_shift_mode_field), .i_status_reg_two_circ(i_status_reg_two_circ),
    .i_mmr(i_mmr), .i_ext(i_ext), .i_temp(i_temp), .i_alu(i_alu), .i_agen(i_agen),
    .i_mult_sel(i_mult_sel), .i_shift_sel(i_shift_sel), .o_mmr_rdata(o_mmr_rdata),
    .o_ext_rdata(o_ext_rdata), .o_data_addr(o_data_addr), .o_coeff_addr(o_coeff_addr),
    .o_mult_operand(o_mult_operand), .o_shift_count(o_shift_count), .o_circ_size(o_circ_size));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // strobes drop one edge after they are taken
  task automatic mmr_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clk) i_mmr <= '{1'b1, a, d};
    @(posedge i_clk) i_mmr.wr <= 1'b0;
  endtask : mmr_wr

  task automatic mmr_rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge i_clk) i_mmr.addr <= a;
    @(posedge i_clk) #1 chk("mmr_rdata", {7'h00, exp}, {7'h00, o_mmr_rdata});
  endtask : mmr_rd

  task automatic ext_wr(input logic [3:0] s, input logic [22:0] d);
    @(posedge i_clk) i_ext <= '{1'b1, s, d};
    @(posedge i_clk) i_ext.wr <= 1'b0;
  endtask : ext_wr

  task automatic ext_rd(input logic [3:0] s, input logic [22:0] exp);
    @(posedge i_clk) i_ext.sel <= s;
    @(posedge i_clk) #1 chk("ext_rdata", exp, o_ext_rdata);
  endtask : ext_rd

  task automatic agen(input aprf_mod_type k, input logic [3:0] s);
    @(posedge i_clk) i_agen <= '{k, s, 16'h0001};
    @(posedge i_clk) i_agen.kind <= APRF_MOD_NONE;
  endtask : agen

  task automatic temp_op(input logic w, input logic [1:0] s, input logic [15:0] d, input logic sw);
    @(posedge i_clk) i_temp <= '{w, s, d, sw, 3'h2};
    @(posedge i_clk) i_temp <= '0;
  endtask : temp_op

  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    i_rst_n = 1'b0;
    {i_legacy_compat_mode, i_accum_shift_mode_field, i_status_reg_two_circ, i_mmr, i_ext, i_temp, i_alu,
      i_agen, i_mult_sel, i_shift_sel} = '0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    mmr_rd(7'h10, 16'h0000);
    // odd patterns: no alignment, no aliasing between places
    foreach (tab[i]) mmr_wr(tab[i], {tab[i], 9'h1B3});
    foreach (tab[i]) mmr_rd(tab[i], {tab[i], 9'h1B3});
    mmr_wr(7'h18, 16'hFFFF);
    mmr_rd(7'h18, 16'h0000);
    mmr_wr(7'h4F, 16'hFFFF);
    mmr_rd(7'h4F, 16'h007F);
    ext_rd(4'h8, {7'h7F, 7'h27, 9'h1B3});
    ext_wr(4'h3, 23'h5A1234);
    ext_rd(4'h3, 23'h5A1234);
    mmr_rd(7'h13, 16'h1234);
    mmr_wr(7'h13, 16'hBEEF);
    mmr_rd(7'h13, 16'hBEEF);
    ext_rd(4'h3, 23'h5ABEEF);
    // selects above the coefficient pointer must not alias onto an aux pointer
    ext_wr(4'hF, 23'h7FFFFF);
    ext_rd(4'h7, 23'h002FB3);
    ext_wr(4'h0, 23'h00FFFF);
    agen(APRF_MOD_LINEAR, 4'h0);
    ext_rd(4'h0, 23'h010000);
    ext_wr(4'h1, 23'h00FFFF);
    agen(APRF_MOD_LOCAL, 4'h1);
    ext_rd(4'h1, 23'h000000);
    // circular offsets: start added only while selected
    mmr_wr(7'h32, 16'h0100);
    ext_wr(4'h1, 23'h120010);
    ext_wr(4'h8, 23'h050002);
    mmr_wr(7'h36, 16'h0010);
    @(posedge i_clk) i_status_reg_two_circ <= 9'h102;
    i_agen.sel <= 4'h1;
    repeat (2) @(posedge i_clk);
    #1 chk("data_addr", 23'h120110, o_data_addr);
    chk("coeff_addr", 23'h050012, o_coeff_addr);
    @(posedge i_clk) i_status_reg_two_circ <= 9'h000;
    repeat (2) @(posedge i_clk);
    #1 chk("data_addr", 23'h120010, o_data_addr);
    // pointer 6 takes the pair 67 start, page still its own
    ext_wr(4'h6, 23'h300020);
    mmr_wr(7'h35, 16'h0300);
    @(posedge i_clk) i_status_reg_two_circ <= 9'h040;
    i_agen.sel <= 4'h6;
    repeat (2) @(posedge i_clk);
    #1 chk("data_addr", 23'h300320, o_data_addr);
    // temps feed multiplier and shifter; swap with a pointer
    @(posedge i_clk) i_mult_sel <= 2'h1;
    i_shift_sel <= 2'h1;
    temp_op(1'b1, 2'h1, 16'h1111, 1'b0);
    #1 chk("mult", 23'h001111, {7'h00, o_mult_operand});
    chk("shift", 23'h001111, {7'h00, o_shift_count});
    mmr_wr(7'h12, 16'h2222);
    temp_op(1'b0, 2'h1, 16'h0000, 1'b1);
    mmr_rd(7'h12, 16'h1111);
    chk("mult", 23'h002222, {7'h00, o_mult_operand});
    // every alu op, each beside an address update on another pointer
    ext_wr(4'h5, 23'h00FFFE);
    for (int k = 1; k < 8; k++) begin
      mmr_wr(7'h14, 16'h0F0F);
      @(posedge i_clk) i_alu <= '{aprf_alu_op_type'(k), 3'h4, 16'h0003};
      i_agen <= '{APRF_MOD_LINEAR, 4'h5, 16'h0001};
      @(posedge i_clk) i_alu.op <= APRF_ALU_NONE;
      i_agen.kind <= APRF_MOD_NONE;
      mmr_rd(7'h14, alu_exp[k-1]);
    end
    ext_rd(4'h5, 23'h010005);
    // legacy code expects every start register cleared first
    for (int k = 0; k < 5; k++) mmr_wr(7'h32 + 7'(k), 16'h0000);
    // legacy mode binds temp 2 and shares the first size
    mmr_wr(7'h19, 16'h0040);
    mmr_wr(7'h30, 16'h0080);
    @(posedge i_clk) i_legacy_compat_mode <= 1'b1;
    i_accum_shift_mode_field <= 5'h13;
    i_mult_sel <= 2'h2;
    i_shift_sel <= 2'h2;
    @(posedge i_clk) #1 chk("mult", 23'h00FFF3, {7'h00, o_mult_operand});
    chk("shift", 23'h00FFF3, {7'h00, o_shift_count});
    chk("size1", 23'h000040, {7'h00, o_circ_size[1]});
    @(posedge i_clk) i_legacy_compat_mode <= 1'b0;
    @(posedge i_clk) #1 chk("size1", 23'h000080, {7'h00, o_circ_size[1]});
    end_sim();
  end
endmodule : test_aprf_regfile
